// File: rtl/dtc_core.sv
// data transfer controller core: software activation, normal-mode moves, info write-back
//
// Notes on behaviour
// R1 - register info is read and written over a 32-bit path, one state each
// R2 - software must enable the on-chip ram before using the controller
// R3 - enable bit 7 gates software activation; reset value zero blocks it
// R4 - software clears the enable bit by reading one, then writing zero
// R5 - enable clears when interrupt-disable select is zero and count not ended
// R6 - enable holds after disable-select end, count end, and during a transfer
// R7 - bits six to zero hold the software activation vector number
// R8 - vector address is base 0x400 plus vector number shifted left once
// R9 - halt bit fourteen stops the controller after the current bus cycle; the code only blocks a new start, a running transfer completes
// R10 - writing one to the halt bit is ignored while busy
// R11 - 16-bit halt register loads 0x3fff on reset and hardware standby
// R12 - each normal-mode operation moves exactly one byte or one word
// R13 - transfer count runs from 1 to 65536, zero meaning 65536
// R14 - when the count is exhausted a cpu interrupt can be raised
// R15 - info supplies source, destination and count a; count b unused
// R16 - count decremented and info written back before next activation
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"
module dtc_core (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic hw_standby_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [31:0] mem_rdata_in,
  output logic [23:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic [3:0] mem_be_out,
  output logic mem_re_out,
  output logic mem_we_out,
  output logic busy_out,
  output logic irq_out
);
  import dtc_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  dtc_mem_if mem ();
  dtc_state_t state;
  logic issued;
  logic [1:0] info_idx;
  logic act_en;
  logic [6:0] act_vec;
  logic clr_armed;
  logic [15:0] mhc;
  logic stby_s1;
  logic stby_s2;
  logic [23:0] info_ptr;
  logic [7:0] mode;
  logic [23:0] source_pointer;
  logic [23:0] destination_pointer;
  logic [15:0] count_register_a;
  logic [15:0] count_register_b;
  logic [15:0] unit;
  logic done_cnt;
  logic [23:0] vec_addr;
  logic [23:0] step;
  logic halt;
  logic is_word;
  logic interrupt_disable_select;
  logic wr_act;
  logic rd_act;
  logic wr_mhc;
  logic start;
  logic [`DTC_IRQ_W-1:0] irq_set;
  logic [`DTC_IRQ_W-1:0] irq_stat;
  logic [`DTC_IRQ_W-1:0] irq_mask;
  logic [15:0] next_unit;
  logic [31:0] next_wdata;
  logic [3:0] next_be;

  assign halt = mhc[`DTC_MHC_HALT_BIT];
  assign is_word = mode[`DTC_MODE_WORD_BIT];
  assign interrupt_disable_select = mode[`DTC_MODE_INTERRUPT_DISABLE_SELECT_BIT];
  assign wr_act = reg_we_in && (reg_addr_in == `DTC_OFF_ACT);
  assign rd_act = reg_re_in && (reg_addr_in == `DTC_OFF_ACT);
  assign wr_mhc = reg_we_in && (reg_addr_in == `DTC_OFF_MHC);
  assign vec_addr = `DTC_VEC_BASE + {16'h0000, act_vec, 1'b0}; // [R8]
  assign step = is_word ? 24'h000002 : 24'h000001;
  // activation only by writing one to the enable bit, never while halted
  assign start = wr_act && reg_wdata_in[`DTC_ACT_EN_BIT] && (state == S_IDLE) && !halt; // [R3] [R9]

  // ----------------------------------------
  // data unit alignment
  // ----------------------------------------
  always_comb
  begin
    next_unit = 16'h0000;
    if (is_word)
      next_unit = source_pointer[1] ? mem.rdata[31:16] : mem.rdata[15:0];
    else
      case (source_pointer[1:0])
        2'h0: next_unit = {8'h00, mem.rdata[7:0]};
        2'h1: next_unit = {8'h00, mem.rdata[15:8]};
        2'h2: next_unit = {8'h00, mem.rdata[23:16]};
        default: next_unit = {8'h00, mem.rdata[31:24]};
      endcase
    // one unit per operation: byte lane or half-word lanes only
    next_wdata = is_word ? {unit, unit} : {4{unit[7:0]}}; // [R12]
    next_be = is_word ? (destination_pointer[1] ? 4'hc : 4'h3) : (4'h1 << destination_pointer[1:0]); // [R12]
  end

  // ----------------------------------------
  // memory requests
  // ----------------------------------------
  always_comb
  begin
    mem.req = 1'b0;
    mem.we = 1'b0;
    mem.addr = 24'h000000;
    mem.wdata = 32'h00000000;
    mem.be = 4'hf;
    if (!issued)
      case (state)
        S_VEC:
        begin
          mem.req = 1'b1;
          mem.addr = {vec_addr[23:2], 2'b00}; // [R8]
        end
        S_INFO:
        begin
          mem.req = 1'b1;
          mem.addr = info_ptr + {20'h00000, info_idx, 2'b00}; // [R1]
        end
        S_SRC:
        begin
          mem.req = 1'b1;
          mem.addr = {source_pointer[23:2], 2'b00}; // [R15]
        end
        S_DST:
        begin
          mem.req = 1'b1;
          mem.we = 1'b1;
          mem.addr = {destination_pointer[23:2], 2'b00}; // [R15]
          mem.wdata = next_wdata;
          mem.be = next_be;
        end
        S_WBACK:
        begin
          mem.req = 1'b1;
          mem.we = 1'b1;
          mem.addr = info_ptr + {20'h00000, info_idx, 2'b00}; // [R16]
          case (info_idx)
            2'h0: mem.wdata = {mode, source_pointer};
            2'h1: mem.wdata = {8'h00, destination_pointer};
            default: mem.wdata = {count_register_b, count_register_a}; // [R15]
          endcase
        end
        default: mem.req = 1'b0;
      endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state <= S_IDLE;
      issued <= 1'b0;
      info_idx <= 2'h0;
    end
    else if (ce_in)
      case (state)
        S_IDLE:
          if (start)
            state <= S_VEC;
        S_VEC, S_INFO, S_SRC:
          if (!issued)
            issued <= 1'b1;
          else if (mem.rvalid)
          begin
            issued <= 1'b0;
            if (state == S_VEC)
            begin
              info_idx <= 2'h0;
              state <= S_INFO;
            end
            else if (state == S_SRC)
              state <= S_DST;
            else if (info_idx == `DTC_INFO_LAST)
              state <= S_SRC;
            else
              info_idx <= info_idx + 2'h1;
          end
        S_DST:
        begin
          info_idx <= 2'h0;
          state <= S_WBACK; // [R16]
        end
        S_WBACK:
          if (info_idx == `DTC_INFO_LAST)
            state <= S_FIN;
          else
            info_idx <= info_idx + 2'h1;
        S_FIN: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
  end

  // ----------------------------------------
  // transfer info registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      info_ptr <= 24'h000000;
      mode <= 8'h00;
      source_pointer <= 24'h000000;
      destination_pointer <= 24'h000000;
      count_register_a <= 16'h0000;
      count_register_b <= 16'h0000;
      unit <= 16'h0000;
      done_cnt <= 1'b0;
    end
    else if (ce_in && issued && mem.rvalid)
      case (state)
        S_VEC:
          // info blocks are word aligned
          info_ptr <= {8'h00, (vec_addr[1] ? mem.rdata[31:16] : mem.rdata[15:0]) & 16'hfffc};
        S_INFO:
          case (info_idx)
            2'h0: {mode, source_pointer} <= mem.rdata; // [R15]
            2'h1: destination_pointer <= mem.rdata[23:0]; // [R15]
            default: {count_register_b, count_register_a} <= mem.rdata; // [R15]
          endcase
        S_SRC: unit <= next_unit; // [R12]
        default: unit <= unit;
      endcase
    else if (ce_in && state == S_DST)
    begin
      if (mode[`DTC_MODE_SINC_BIT])
        source_pointer <= source_pointer + step;
      if (mode[`DTC_MODE_DINC_BIT])
        destination_pointer <= destination_pointer + step;
      // zero wraps to 0xffff, so a count of zero runs 65536 times
      count_register_a <= count_register_a - 16'h0001; // [R13] [R16]
      done_cnt <= (count_register_a == 16'h0001); // [R13]
    end
  end

  // ----------------------------------------
  // software activation register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      act_en <= 1'b0; // [R3]
      act_vec <= 7'h00;
      clr_armed <= 1'b0;
    end
    else if (ce_in)
    begin
      if (state == S_FIN && !interrupt_disable_select && !done_cnt)
        act_en <= 1'b0; // [R5]
      else if (state == S_IDLE && wr_act)
      begin
        // writes during a transfer are dropped so the bit holds at one
        act_vec <= reg_wdata_in[6:0]; // [R7] [R6]
        if (reg_wdata_in[`DTC_ACT_EN_BIT])
          act_en <= 1'b1;
        else if (clr_armed)
          act_en <= 1'b0; // [R4]
      end
      if (rd_act && act_en)
        clr_armed <= 1'b1; // [R4]
      else if (wr_act)
        clr_armed <= 1'b0;
    end
  end

  // ----------------------------------------
  // halt register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      stby_s1 <= 1'b0;
      stby_s2 <= 1'b0;
    end
    else if (ce_in)
    begin
      stby_s1 <= hw_standby_in;
      stby_s2 <= stby_s1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mhc <= `DTC_MHC_RESET; // [R11]
    else if (ce_in)
    begin
      if (stby_s2)
        mhc <= `DTC_MHC_RESET; // [R11]
      else if (wr_mhc)
      begin
        mhc <= reg_wdata_in[15:0];
        if (state != S_IDLE)
          mhc[`DTC_MHC_HALT_BIT] <= mhc[`DTC_MHC_HALT_BIT]; // [R10]
      end
    end
  end

  // ----------------------------------------
  // events, read-back, outputs
  // ----------------------------------------
  assign irq_set[`DTC_IRQ_XFER_BIT] = (state == S_FIN);
  assign irq_set[`DTC_IRQ_COUNT_BIT] = (state == S_FIN) && (done_cnt || interrupt_disable_select); // [R14]

  dtc_irq #(.W(`DTC_IRQ_W)) u_irq (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .set_in(irq_set),
    .clr_we_in(reg_we_in && (reg_addr_in == `DTC_OFF_ISTAT)),
    .mask_we_in(reg_we_in && (reg_addr_in == `DTC_OFF_IMASK)),
    .wdata_in(reg_wdata_in[`DTC_IRQ_W-1:0]),
    .status_out(irq_stat),
    .mask_out(irq_mask),
    .irq_out(irq_out)
  );

  dtc_mem_port u_port (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .mem(mem.port),
    .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_be_out(mem_be_out),
    .mem_re_out(mem_re_out),
    .mem_we_out(mem_we_out)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 32'h00000000;
      busy_out <= 1'b0;
    end
    else if (ce_in)
    begin
      busy_out <= (state != S_IDLE);
      reg_rdata_out <= 32'h00000000;
      if (reg_re_in)
        case (reg_addr_in)
          `DTC_OFF_ACT: reg_rdata_out <= {24'h000000, act_en, act_vec};
          `DTC_OFF_MHC: reg_rdata_out <= {16'h0000, mhc};
          `DTC_OFF_ISTAT: reg_rdata_out <= {30'h0, irq_stat};
          `DTC_OFF_IMASK: reg_rdata_out <= {30'h0, irq_mask};
          `DTC_OFF_STAT: reg_rdata_out <= {count_register_a, 13'h0000, act_en, halt, state != S_IDLE};
          default: reg_rdata_out <= 32'h00000000;
        endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_vec_addr;
    (ce_in && state == S_VEC && mem.req) |=>
      mem_re_out && mem_addr_out[23:2] == $past(vec_addr[23:2]);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // [R8]
  property p_act_clear;
    (ce_in && state == S_FIN && !interrupt_disable_select && !done_cnt) |=> !act_en;
  endproperty
  a_act_clear: assert property (p_act_clear) else $error("enable not cleared"); // [R5]
  property p_act_hold;
    (state != S_IDLE) |-> act_en;
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("enable dropped during transfer"); // [R6]
  property p_start_gate;
    (ce_in && state == S_IDLE && !(wr_act && reg_wdata_in[`DTC_ACT_EN_BIT])) |=> state == S_IDLE;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start without enable"); // [R3]
  property p_halt_stop;
    (ce_in && halt && state == S_IDLE) |=> state == S_IDLE;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("started while halted"); // [R9]
  property p_halt_lock;
    (ce_in && wr_mhc && state != S_IDLE && !stby_s2) |=> mhc[`DTC_MHC_HALT_BIT] == $past(halt);
  endproperty
  a_halt_lock: assert property (p_halt_lock) else $error("halt written while busy"); // [R10]
  property p_mhc_reset;
    disable iff (1'b0) sys_rst_in |=> mhc == 16'h3fff;
  endproperty
  a_mhc_reset: assert property (p_mhc_reset) else $error("halt register reset value"); // [R11]
  property p_one_unit;
    (ce_in && state == S_DST) |=>
      mem_we_out && $countones(mem_be_out) == (is_word ? 2 : 1);
  endproperty
  a_one_unit: assert property (p_one_unit) else $error("not one unit moved"); // [R12]
  property p_count_dec;
    (ce_in && state == S_DST) |=> count_register_a == 16'($past(count_register_a) - 16'h0001) && state == S_WBACK;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented"); // [R13]
  property p_wback;
    (ce_in && state == S_DST) ##1 ce_in [*3] |-> ##1 state == S_FIN;
  endproperty
  a_wback: assert property (p_wback) else $error("write-back not finished"); // [R16]
  property p_irq;
    (ce_in && state == S_FIN && done_cnt && irq_mask[`DTC_IRQ_COUNT_BIT]) |-> ##[1:3] irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("count end interrupt missing"); // [R14]

  c_start: cover property (ce_in && start);
  c_count_end: cover property (state == S_FIN && done_cnt);
  c_halt_blocked: cover property (wr_mhc && state != S_IDLE && reg_wdata_in[14]);
  c_enable_cleared: cover property (ce_in && state == S_FIN && !interrupt_disable_select && !done_cnt);
endmodule : dtc_core
`default_nettype wire

// File: shared/dtc_defs.svh
// register offsets, field positions, reset values and fixed addresses of the transfer controller
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DTC_OFF_ACT 8'h00
`define DTC_OFF_MHC 8'h04
`define DTC_OFF_ISTAT 8'h08
`define DTC_OFF_IMASK 8'h0c
`define DTC_OFF_STAT 8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DTC_ACT_EN_BIT 7
`define DTC_MHC_HALT_BIT 14
`define DTC_MHC_RESET 16'h3fff
`define DTC_VEC_BASE 24'h000400
`define DTC_MODE_WORD_BIT 0
`define DTC_MODE_INTERRUPT_DISABLE_SELECT_BIT 1
`define DTC_MODE_SINC_BIT 2
`define DTC_MODE_DINC_BIT 3
`define DTC_IRQ_XFER_BIT 0
`define DTC_IRQ_COUNT_BIT 1
`define DTC_IRQ_W 2
`define DTC_INFO_LAST 2'h2
`define DTC_STAT_BUSY_BIT 0
`define DTC_STAT_HALT_BIT 1
`define DTC_STAT_EN_BIT 2

`endif

// File: shared/dtc_pkg.sv
// types shared by the transfer controller modules
package dtc_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_VEC = 7'h02,
    S_INFO = 7'h04,
    S_SRC = 7'h08,
    S_DST = 7'h10,
    S_WBACK = 7'h20,
    S_FIN = 7'h40
  } dtc_state_t;
endpackage : dtc_pkg

// File: shared/dtc_mem_if.sv
// request and answer path between the controller core and its 32-bit memory port
`timescale 1ns/1ps
`default_nettype none
interface dtc_mem_if;
  logic req;
  logic we;
  logic [23:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic rvalid;
  modport core (output req, output we, output addr, output wdata, output be,
                input rdata, input rvalid);
  modport port (input req, input we, input addr, input wdata, input be,
                output rdata, output rvalid);
endinterface : dtc_mem_if
`default_nettype wire

// File: rtl/dtc_mem_port.sv
// registered 32-bit memory port: one state per access, read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module dtc_mem_port (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  dtc_mem_if.port mem,
  input wire logic [31:0] mem_rdata_in,
  output logic [23:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic [3:0] mem_be_out,
  output logic mem_re_out,
  output logic mem_we_out
);
  import dtc_pkg::*;

  // ----------------------------------------
  // request registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      mem_addr_out <= 24'h000000;
      mem_wdata_out <= 32'h00000000;
      mem_be_out <= 4'h0;
      mem_re_out <= 1'b0;
      mem_we_out <= 1'b0;
    end
    else if (ce_in)
    begin
      mem_addr_out <= mem.addr;
      mem_wdata_out <= mem.wdata;
      mem_be_out <= mem.we ? mem.be : 4'hf;
      mem_re_out <= mem.req & ~mem.we; // [R1]
      mem_we_out <= mem.req & mem.we; // [R1]
    end
  end

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mem.rvalid <= 1'b0;
    else if (ce_in)
      mem.rvalid <= mem_re_out; // [R1]
  end

  // same clock as the ram, so no synchroniser on the data
  assign mem.rdata = mem_rdata_in;

  property p_one_state;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (ce_in && mem_re_out) |=> mem.rvalid;
  endproperty
  a_one_state: assert property (p_one_state) else $error("read answer not one state later"); // [R1]
endmodule : dtc_mem_port
`default_nettype wire

// File: rtl/dtc_irq.sv
// sticky event status with write-one-to-clear, mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module dtc_irq #(
  parameter int W = 2
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] set_in,
  input wire logic clr_we_in,
  input wire logic mask_we_in,
  input wire logic [W-1:0] wdata_in,
  output logic [W-1:0] status_out,
  output logic [W-1:0] mask_out,
  output logic irq_out
);
  import dtc_pkg::*;

  // ----------------------------------------
  // status, mask, line
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      status_out <= '0;
    else if (ce_in)
      // set wins over a clear in the same cycle
      status_out <= (status_out & ~(clr_we_in ? wdata_in : '0)) | set_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mask_out <= '0;
    else if (ce_in && mask_we_in)
      mask_out <= wdata_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_out <= 1'b0;
    else if (ce_in)
      irq_out <= |(status_out & mask_out);
  end
endmodule : dtc_irq
`default_nettype wire

// File: tb/dtc_ram_model.sv
// behavioural on-chip ram holding the transfer register information
`timescale 1ns/1ps
`default_nettype none
module dtc_ram_model (
  input wire logic clk_sys_in,
  input wire logic re_in,
  input wire logic we_in,
  input wire logic [23:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] be_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:1023];
  initial rdata_out = 32'h0;
  // ram taken as enabled by software before any use
  // every 32-bit access done in one state, never a wait
  always @(posedge clk_sys_in)
  begin
    // idle cycles toggle so stale data never passes as valid
    rdata_out <= re_in ? mem[addr_in[11:2]] : ~rdata_out;
    if (we_in)
      for (int i = 0; i < 4; i++)
        if (be_in[i])
          mem[addr_in[11:2]][8*i +: 8] <= wdata_in[8*i +: 8];
  end
endmodule : dtc_ram_model
`default_nettype wire

// File: tb/dtc_core_bench.sv
// self-checking bench for the transfer controller core
`timescale 1ns/1ps
`default_nettype none
module dtc_core_bench;
  logic clk_sys_in, sys_rst_in, ce_in, hw_standby_in;
  logic reg_we_in, reg_re_in, mem_re_out, mem_we_out, busy_out, irq_out;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, mem_rdata_in, mem_wdata_out, d;
  logic [23:0] mem_addr_out;
  logic [3:0] mem_be_out;
  int fail_count, n_tests, cyc;

  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  dtc_core dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .hw_standby_in(hw_standby_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_we_in(reg_we_in), .reg_re_in(reg_re_in),
    .reg_rdata_out(reg_rdata_out), .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_be_out(mem_be_out), .mem_re_out(mem_re_out), .mem_we_out(mem_we_out),
    .busy_out(busy_out), .irq_out(irq_out));

  dtc_ram_model ram (.clk_sys_in(clk_sys_in), .re_in(mem_re_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
    .rdata_out(mem_rdata_in));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // tests need well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    reg_we_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_we_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    reg_re_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_re_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd

  task automatic wait_done;
    int k;
    k = 0;
    #1;
    while (busy_out !== 1'b0 && k < 100)
    begin
      @(posedge clk_sys_in);
      #1 k++;
    end
    repeat (3) @(posedge clk_sys_in);
  endtask : wait_done

  // start by software and check the vector fetch address
  task automatic run(input logic [6:0] v, input logic [23:0] va);
    int k;
    wr(8'h00, {24'h0, 1'b1, v});
    k = 0;
    #1;
    while (mem_re_out !== 1'b1 && k < 20)
    begin
      @(posedge clk_sys_in);
      #1 k++;
    end
    check("vector addr", {8'h0, mem_addr_out}, {8'h0, va});
    check("busy", {31'h0, busy_out}, 32'h1);
    wait_done();
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(8'h04, d);
    check("halt reset", d, 32'h3fff);
    rd(8'h00, d);
    check("act reset", d, 32'h0);
    rd(8'h30, d);
    check("unmapped", d, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_gate;
    // a start write while the clock enable is low must leave no trace
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    wr(8'h00, 32'h90);
    ce_in <= 1'b1;
    wr(8'h00, 32'h10);
    repeat (6) @(posedge clk_sys_in);
    #1 check("no start", {31'h0, busy_out}, 32'h0);
    rd(8'h00, d);
    check("vector", d, 32'h10);
    $display("test gate done");
  endtask : t_gate

  task automatic t_byte;
    run(7'h10, 24'h420);
    check("dst byte", ram.mem[10'hd0], 32'h00220000);
    check("info w0", ram.mem[10'h80], 32'h0c000302);
    check("info w1", ram.mem[10'h81], 32'h00000343);
    check("info w2", ram.mem[10'h82], 32'habcd0001);
    rd(8'h00, d);
    check("en cleared", d, 32'h10);
    rd(8'h08, d);
    check("status", d, 32'h1);
    check("irq masked", {31'h0, irq_out}, 32'h0);
    wr(8'h0c, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    #1 check("irq", {31'h0, irq_out}, 32'h1);
    wr(8'h08, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    #1 check("irq clr", {31'h0, irq_out}, 32'h0);
    $display("test byte done");
  endtask : t_byte

  task automatic t_word;
    // only the count-end event may raise the line in this run
    wr(8'h0c, 32'h2);
    run(7'h11, 24'h420);
    check("dst word", ram.mem[10'hd0], 32'h00224433);
    check("irq count", {31'h0, irq_out}, 32'h1);
    check("info w2b", ram.mem[10'h92], 32'h00000000);
    rd(8'h08, d);
    check("count end", d, 32'h3);
    wr(8'h08, 32'h3);
    // a zero written without a read of one must not clear
    wr(8'h00, 32'h11);
    rd(8'h00, d);
    check("en held", d, 32'h91);
    wr(8'h00, 32'h11);
    rd(8'h00, d);
    check("en sw clr", d, 32'h11);
    $display("test word done");
  endtask : t_word

  task automatic t_halt;
    wr(8'h00, 32'h90);
    wr(8'h04, 32'h7fff);
    wait_done();
    rd(8'h04, d);
    check("halt busy", d, 32'h3fff);
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h7fff);
    rd(8'h04, d);
    check("halt set", d, 32'h7fff);
    wr(8'h00, 32'h90);
    repeat (6) @(posedge clk_sys_in);
    #1 check("halted", {31'h0, busy_out}, 32'h0);
    @(posedge clk_sys_in);
    hw_standby_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    hw_standby_in <= 1'b0;
    rd(8'h04, d);
    check("standby", d, 32'h3fff);
    $display("test halt done");
  endtask : t_halt

  task automatic t_count0;
    ram.mem[10'h82] = 32'habcd0000;
    run(7'h10, 24'h420);
    check("count 65536", ram.mem[10'h82], 32'habcdffff);
    rd(8'h08, d);
    check("not ended", d, 32'h1);
    check("count0 irq", {31'h0, irq_out}, 32'h0);
    rd(8'h10, d);
    check("status reg", d, 32'hffff0000);
    $display("test count0 done");
  endtask : t_count0

  initial
  begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    hw_standby_in = 1'b0;
    reg_we_in = 1'b0;
    reg_re_in = 1'b0;
    reg_addr_in = 8'h0;
    reg_wdata_in = 32'h0;
    fail_count = 0;
    n_tests = 0;
    // vector 0x10 low half, vector 0x11 high half
    ram.mem[10'h108] = 32'h02400200;
    ram.mem[10'h80] = 32'h0c000301;
    ram.mem[10'h81] = 32'h00000342;
    ram.mem[10'h82] = 32'habcd0002;
    ram.mem[10'h90] = 32'h01000302;
    ram.mem[10'h91] = 32'h00000340;
    ram.mem[10'h92] = 32'h00000001;
    ram.mem[10'hc0] = 32'h44332211;
    ram.mem[10'hd0] = 32'h0;
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_gate();
    t_byte();
    t_word();
    t_halt();
    t_count0();
    stop_test();
  end
endmodule : dtc_core_bench
`default_nettype wire
